// ===== rtl/tac_defines.vh
// Constants for the touch and auxiliary conversion sequencer.
// Assumes a single 100 MHz clock; included by bare name.
`ifndef TAC_DEFINES_VH
`define TAC_DEFINES_VH

// ****************************************
// Timing
// ****************************************
`define TAC_CLK_MHZ 100
`define TAC_OVH_TOUCH_NS 2125
`define TAC_OVH_SENSOR_NS 2625
`define TAC_CONV_TAIL_NS 4400
// Cycle counts at 100 MHz, rounded up
`define TAC_OVH_TOUCH_CYC 213
`define TAC_OVH_SENSOR_CYC 263
`define TAC_CONV_TAIL_CYC 440

// ****************************************
// Commands
// ****************************************
`define TAC_CMD_NONE 5'h00
`define TAC_CMD_SCAN_XY 5'h01
`define TAC_CMD_SCAN_XYZ 5'h02
`define TAC_CMD_SINGLE_X 5'h03
`define TAC_CMD_SINGLE_Y 5'h04
`define TAC_CMD_SINGLE_Z 5'h05
`define TAC_CMD_DRIVE_X 5'h06
`define TAC_CMD_DRIVE_Y 5'h07
`define TAC_CMD_DRIVE_Z 5'h08
`define TAC_CMD_CONV_X 5'h09
`define TAC_CMD_CONV_Y 5'h0A
`define TAC_CMD_CONV_Z 5'h0B
`define TAC_CMD_TEMP_LOW 5'h0C
`define TAC_CMD_TEMP_HIGH 5'h0D
`define TAC_CMD_BAT_QUARTER 5'h0E
`define TAC_CMD_BAT_HALF 5'h0F
`define TAC_CMD_AUX_A 5'h10
`define TAC_CMD_AUX_B 5'h11

// ****************************************
// Result slots (read addresses)
// ****************************************
`define TAC_SLOT_X 4'h0
`define TAC_SLOT_Y 4'h1
`define TAC_SLOT_Z1 4'h2
`define TAC_SLOT_Z2 4'h3
`define TAC_SLOT_BAT_QUARTER 4'h4
`define TAC_SLOT_BAT_HALF 4'h5
`define TAC_SLOT_AUX_A 4'h6
`define TAC_SLOT_AUX_B 4'h7
`define TAC_SLOT_TEMP_LOW 4'h8
`define TAC_SLOT_TEMP_HIGH 4'h9
`define TAC_SLOT_COUNT 10

// ****************************************
// Resolution select and reset values
// ****************************************
`define TAC_RES_12 2'h0
`define TAC_RES_8 2'h1
`define TAC_RES_10 2'h2
`define TAC_RESULT_RESET 16'h0000

`endif

// ===== rtl/tac_sequencer.v
// Conversion sequencer for touch, temperature, battery and auxiliary inputs.
// Assumes command and read strobes come from same-clock SPI logic; pen detect is asynchronous.
//
// Notes on behaviour
// - Touch drives pen interrupt low; host command picks a single conversion or a one-pass XY or XYZ scan.
// - No scan starts on touch alone; only a host command starts one.
// - Host-controlled coordinate takes 2.125us, settle, and per average bits times period plus 4.4us.
// - Temperature, battery, auxiliary take 2.625us, reference delay, and same per-average time.
// - Second temperature uses 82x bias; results go to separate registers.
// - Battery divider enabled only while battery input is sampled.
// - Auxiliary inputs use battery flow without any divider.
// - Data-ready low on new results, high again once all are read.
// - Results right-justified in 16 bits, upper bits zero.
`timescale 1ns/1ps
`include "tac_defines.vh"

module tac_sequencer (
    input wire clk,
    input wire reset,
    input wire penDetect,
    input wire cmdValid,
    input wire [4:0] cmdCode,
    input wire [1:0] resSel,
    input wire [1:0] avgSel,
    input wire [7:0] convPeriod,
    input wire [15:0] settleCycles,
    input wire [15:0] refDelayCycles,
    input wire [11:0] adcData,
    input wire rdStrobe,
    input wire [3:0] rdAddr,
    output reg [15:0] rdData_q,
    output reg penTouchIrqN_q,
    output reg resultReadyN_q,
    output reg adcStart_q,
    output reg [3:0] adcChan_q,
    output reg xDrive_q,
    output reg yDrive_q,
    output reg zDrive_q,
    output reg batQuarterDivEn_q,
    output reg batHalfDivEn_q,
    output reg tempHighBias_q,
    output reg refPowerUp_q,
    output reg busy_q
);

    // ****************************************
    // Functions
    // ****************************************
    localparam ST_IDLE = 3'h0;
    localparam ST_PRE = 3'h1;
    localparam ST_SETTLE = 3'h2;
    localparam ST_CONV = 3'h3;
    localparam ST_DONE = 3'h4;

    // Returns {last step, result slot}
    function [4:0] planStep;
        input [4:0] cmd;
        input [2:0] idx;
        begin
            case (cmd)
                `TAC_CMD_SCAN_XY: begin
                    planStep = (idx == 3'h0) ? {1'b0, `TAC_SLOT_Y} : {1'b1, `TAC_SLOT_X};
                end
                `TAC_CMD_SCAN_XYZ: begin
                    case (idx)
                        3'h0: planStep = {1'b0, `TAC_SLOT_Y};
                        3'h1: planStep = {1'b0, `TAC_SLOT_X};
                        3'h2: planStep = {1'b0, `TAC_SLOT_Z1};
                        default: planStep = {1'b1, `TAC_SLOT_Z2};
                    endcase
                end
                `TAC_CMD_SINGLE_X, `TAC_CMD_CONV_X: planStep = {1'b1, `TAC_SLOT_X};
                `TAC_CMD_SINGLE_Y, `TAC_CMD_CONV_Y: planStep = {1'b1, `TAC_SLOT_Y};
                `TAC_CMD_SINGLE_Z, `TAC_CMD_CONV_Z: begin
                    planStep = (idx == 3'h0) ? {1'b0, `TAC_SLOT_Z1} : {1'b1, `TAC_SLOT_Z2};
                end
                `TAC_CMD_TEMP_LOW: planStep = {1'b1, `TAC_SLOT_TEMP_LOW};
                `TAC_CMD_TEMP_HIGH: planStep = {1'b1, `TAC_SLOT_TEMP_HIGH};
                `TAC_CMD_BAT_QUARTER: planStep = {1'b1, `TAC_SLOT_BAT_QUARTER};
                `TAC_CMD_BAT_HALF: planStep = {1'b1, `TAC_SLOT_BAT_HALF};
                `TAC_CMD_AUX_A: planStep = {1'b1, `TAC_SLOT_AUX_A};
                `TAC_CMD_AUX_B: planStep = {1'b1, `TAC_SLOT_AUX_B};
                default: planStep = {1'b1, `TAC_SLOT_X};
            endcase
        end
    endfunction

    function [3:0] resBits;
        input [1:0] sel;
        begin
            case (sel)
                `TAC_RES_8: resBits = 4'h8;
                `TAC_RES_10: resBits = 4'hA;
                default: resBits = 4'hC;
            endcase
        end
    endfunction

    // ****************************************
    // State
    // ****************************************
    reg [2:0] state_q;
    reg [4:0] cmd_q;
    reg [2:0] idx_q;
    reg [23:0] cnt_q;
    reg [3:0] avgCnt_q;
    reg [15:0] acc_q;
    reg [15:0] result_q [0:`TAC_SLOT_COUNT-1];
    reg [9:0] newMask_q;
    reg [2:0] drvHold_q;
    reg penMeta_q;
    reg penSync_q;

    wire [4:0] step = planStep(cmd_q, idx_q);
    wire [3:0] slot = step[3:0];
    wire lastStep = step[4];
    wire touchSlot = (slot <= `TAC_SLOT_Z2);
    wire active = (state_q == ST_SETTLE) || (state_q == ST_CONV);
    wire [3:0] bits = resBits(resSel);
    wire [3:0] avgLast = (4'h1 << avgSel) - 4'h1;
    wire [11:0] sample = adcData >> (4'hC - bits);
    wire [15:0] accNext = acc_q + {4'h0, sample};
    wire [15:0] average = acc_q >> avgSel;
    wire [11:0] convBits = {8'h00, bits} * {4'h0, convPeriod};
    wire [23:0] convTarget = {12'h000, convBits} + 24'd`TAC_CONV_TAIL_CYC;
    wire [23:0] preTarget = touchSlot ? 24'd`TAC_OVH_TOUCH_CYC : 24'd`TAC_OVH_SENSOR_CYC;
    wire [23:0] settleTarget = (slot == `TAC_SLOT_Z2) ? 24'h000001 :
                               touchSlot ? {8'h00, settleCycles} : {8'h00, refDelayCycles};
    wire isDrive = (cmdCode >= `TAC_CMD_DRIVE_X) && (cmdCode <= `TAC_CMD_DRIVE_Z);
    wire isConvCmd = (cmdCode != `TAC_CMD_NONE) && !isDrive && (cmdCode <= `TAC_CMD_AUX_B);

    reg [9:0] setMask;
    reg [9:0] clrMask;
    reg [9:0] newMask_d;

    always @* begin
        setMask = 10'h000;
        clrMask = 10'h000;
        if (state_q == ST_DONE) begin
            setMask[slot] = 1'b1;
        end
        if (rdStrobe && rdAddr < `TAC_SLOT_COUNT) begin
            clrMask[rdAddr] = 1'b1;
        end
        newMask_d = (newMask_q & ~clrMask) | setMask;
    end

    // ****************************************
    // Sequencer
    // ****************************************
    integer i;
    always @(posedge clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            cmd_q <= `TAC_CMD_NONE;
            idx_q <= 3'h0;
            cnt_q <= 24'h000000;
            avgCnt_q <= 4'h0;
            acc_q <= 16'h0000;
            drvHold_q <= 3'h0;
            adcStart_q <= 1'b0;
            for (i = 0; i < `TAC_SLOT_COUNT; i = i + 1) begin
                result_q[i] <= `TAC_RESULT_RESET;
            end
        end else begin
            adcStart_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    // Touch alone never starts a scan
                    if (cmdValid && isDrive) begin
                        drvHold_q <= 3'h1 << (cmdCode - `TAC_CMD_DRIVE_X);
                    end else if (cmdValid && isConvCmd) begin
                        cmd_q <= cmdCode;
                        idx_q <= 3'h0;
                        cnt_q <= 24'h000000;
                        state_q <= ST_PRE;
                    end
                end
                ST_PRE: begin
                    cnt_q <= cnt_q + 24'h000001;
                    if (cnt_q >= preTarget - 24'h000001) begin
                        cnt_q <= 24'h000000;
                        state_q <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    cnt_q <= cnt_q + 24'h000001;
                    if (cnt_q + 24'h000001 >= settleTarget) begin
                        cnt_q <= 24'h000000;
                        avgCnt_q <= 4'h0;
                        acc_q <= 16'h0000;
                        adcStart_q <= 1'b1;
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    cnt_q <= cnt_q + 24'h000001;
                    if (cnt_q >= convTarget - 24'h000001) begin
                        cnt_q <= 24'h000000;
                        acc_q <= accNext;
                        if (avgCnt_q == avgLast) begin
                            state_q <= ST_DONE;
                        end else begin
                            avgCnt_q <= avgCnt_q + 4'h1;
                            adcStart_q <= 1'b1;
                        end
                    end
                end
                ST_DONE: begin
                    result_q[slot] <= {4'h0, average[11:0]};
                    if (lastStep) begin
                        drvHold_q <= 3'h0;
                        state_q <= ST_IDLE;
                    end else begin
                        idx_q <= idx_q + 3'h1;
                        state_q <= ST_SETTLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always @(posedge clk) begin
        if (reset) begin
            penMeta_q <= 1'b0;
            penSync_q <= 1'b0;
            penTouchIrqN_q <= 1'b1;
            newMask_q <= 10'h000;
            resultReadyN_q <= 1'b1;
            rdData_q <= 16'h0000;
            adcChan_q <= 4'h0;
            xDrive_q <= 1'b0;
            yDrive_q <= 1'b0;
            zDrive_q <= 1'b0;
            batQuarterDivEn_q <= 1'b0;
            batHalfDivEn_q <= 1'b0;
            tempHighBias_q <= 1'b0;
            refPowerUp_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            penMeta_q <= penDetect;
            penSync_q <= penMeta_q;
            penTouchIrqN_q <= ~penSync_q;
            newMask_q <= newMask_d;
            resultReadyN_q <= ~|newMask_d;
            if (rdStrobe) begin
                rdData_q <= (rdAddr < `TAC_SLOT_COUNT) ? result_q[rdAddr] : 16'h0000;
            end
            adcChan_q <= slot;
            xDrive_q <= drvHold_q[0] | (active && slot == `TAC_SLOT_X);
            yDrive_q <= drvHold_q[1] | (active && slot == `TAC_SLOT_Y);
            zDrive_q <= drvHold_q[2] | (active && touchSlot && slot >= `TAC_SLOT_Z1);
            batQuarterDivEn_q <= (state_q == ST_CONV) && (slot == `TAC_SLOT_BAT_QUARTER);
            batHalfDivEn_q <= (state_q == ST_CONV) && (slot == `TAC_SLOT_BAT_HALF);
            tempHighBias_q <= active && (slot == `TAC_SLOT_TEMP_HIGH);
            refPowerUp_q <= active && !touchSlot;
            busy_q <= (state_q != ST_IDLE);
        end
    end

endmodule

// ===== tb/tac_adc_model.sv
// Converter model feeding the sequencer's sample input.
// Assumes the bench sets the level that each run should convert.
`timescale 1ns/1ps
module tac_adc_model (
    input wire clk,
    input wire busy_q,
    input wire [3:0] adcChan_q,
    input wire refPowerUp_q,
    input wire [11:0] level,
    output reg [11:0] adcData
);
    // ****************************************
    // Sample output
    // ****************************************
    // Sensor slots read garbage unless the reference is up
    always @(posedge clk) begin
        adcData <= (busy_q && (adcChan_q < 4'h4 || refPowerUp_q)) ? level : ~adcData;
    end
endmodule

// ===== tb/tac_sequencer_props.sv
// Checker for the sequencer's ports.
// Assumes one clock and synchronous reset.
`timescale 1ns/1ps
`include "tac_defines.vh"
module tac_sequencer_props (
    input wire clk,
    input wire reset,
    input wire penDetect,
    input wire cmdValid,
    input wire rdStrobe,
    input wire [15:0] rdData_q,
    input wire penTouchIrqN_q,
    input wire resultReadyN_q,
    input wire adcStart_q,
    input wire [3:0] adcChan_q,
    input wire batQuarterDivEn_q,
    input wire batHalfDivEn_q,
    input wire tempHighBias_q,
    input wire refPowerUp_q,
    input wire busy_q
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    irq_follows_pen_a:
        assert property (!$past(reset) && !$past(reset, 2) && !$past(reset, 3)
            |-> penTouchIrqN_q == !$past(penDetect, 3)) else $error("pen irq wrong");
    no_self_start_a:
        assert property ($rose(busy_q) |-> $past(cmdValid) || $past(cmdValid, 2)) else $error("run without command");
    start_when_busy_a:
        assert property (adcStart_q |-> busy_q) else $error("conversion while idle");
    quarter_div_a:
        assert property (batQuarterDivEn_q |-> adcChan_q == `TAC_SLOT_BAT_QUARTER) else $error("quarter divider on");
    half_div_a:
        assert property (batHalfDivEn_q |-> adcChan_q == `TAC_SLOT_BAT_HALF) else $error("half divider on");
    aux_no_div_a:
        assert property (busy_q && (adcChan_q == `TAC_SLOT_AUX_A || adcChan_q == `TAC_SLOT_AUX_B)
            |-> !batQuarterDivEn_q && !batHalfDivEn_q) else $error("divider on aux");
    high_bias_a:
        assert property (tempHighBias_q |-> adcChan_q == `TAC_SLOT_TEMP_HIGH && refPowerUp_q) else $error("bias wrong");
    upper_zero_a:
        assert property (rdData_q[15:12] == 4'h0) else $error("upper bits set");
    ready_clear_a:
        assert property ($rose(resultReadyN_q) |-> $past(rdStrobe)) else $error("ready cleared unread");
    cover property ($fell(resultReadyN_q));
    cover property (batHalfDivEn_q && adcStart_q);
    cover property (tempHighBias_q && adcStart_q);
endmodule
bind tac_sequencer tac_sequencer_props u_props (.clk(clk), .reset(reset), .penDetect(penDetect), .cmdValid(cmdValid),
    .rdStrobe(rdStrobe), .rdData_q(rdData_q), .penTouchIrqN_q(penTouchIrqN_q), .resultReadyN_q(resultReadyN_q),
    .adcStart_q(adcStart_q), .adcChan_q(adcChan_q), .batQuarterDivEn_q(batQuarterDivEn_q),
    .batHalfDivEn_q(batHalfDivEn_q), .tempHighBias_q(tempHighBias_q), .refPowerUp_q(refPowerUp_q), .busy_q(busy_q));

// ===== tb/tac_sequencer_tb.sv
// Self-checking bench for the conversion sequencer.
// Assumes the converter model and the bound checker.
`timescale 1ns/1ps
`include "tac_defines.vh"
module tac_sequencer_tb;
    reg [7:0] convP = 8'h02;
    reg [15:0] settleC = 16'h0005, refC = 16'h0007;
    reg clk = 0, reset = 1, penDetect = 0, cmdValid = 0, rdStrobe = 0;
    reg [4:0] cmdCode = 5'h00;
    reg [1:0] resSel = 2'h0, avgSel = 2'h0;
    reg [3:0] rdAddr = 4'h0;
    reg [11:0] level = 12'h000;
    wire [11:0] adcData;
    wire [15:0] rdData_q;
    wire [3:0] adcChan_q;
    wire irqN, readyN, adcStart, xDrv, yDrv, zDrv, divQ, divH, bias, refUp, busy;
    integer n_fail = 0, comparisons = 0, i, t0, seed;
    reg [15:0] v;
    reg [4:0] cmdTab [0:9];
    reg [3:0] slotTab [0:9];
    tac_sequencer u_dut (.clk(clk), .reset(reset), .penDetect(penDetect), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .resSel(resSel), .avgSel(avgSel), .convPeriod(convP), .settleCycles(settleC), .refDelayCycles(refC),
        .adcData(adcData), .rdStrobe(rdStrobe), .rdAddr(rdAddr), .rdData_q(rdData_q), .penTouchIrqN_q(irqN),
        .resultReadyN_q(readyN), .adcStart_q(adcStart), .adcChan_q(adcChan_q), .xDrive_q(xDrv), .yDrive_q(yDrv),
        .zDrive_q(zDrv), .batQuarterDivEn_q(divQ), .batHalfDivEn_q(divH), .tempHighBias_q(bias),
        .refPowerUp_q(refUp), .busy_q(busy));
    tac_adc_model u_adc (.clk(clk), .busy_q(busy), .adcChan_q(adcChan_q), .refPowerUp_q(refUp), .level(level),
        .adcData(adcData));
    // ****************************************
    // Helpers
    // ****************************************
    initial begin
        forever #5 clk = ~clk;
    end
    function integer etime(input integer sens, input integer a, input integer r);
        integer s;
        s = sens ? refC : settleC;
        etime = (sens ? `TAC_OVH_SENSOR_CYC : `TAC_OVH_TOUCH_CYC) + (s > 0 ? s : 1) + 1
            + (1 << a) * ((r == 0 ? 12 : r == 1 ? 8 : 10) * convP + `TAC_CONV_TAIL_CYC);
    endfunction
    function [15:0] exp_res(input [11:0] l, input [1:0] r);
        exp_res = {4'h0, l >> (r == 2'h1 ? 4 : r == 2'h2 ? 2 : 0)};
    endfunction
    task check_val(input string nm, input [15:0] e, input [15:0] s);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task check_time(input string nm, input integer e, input integer s);
        comparisons++;
        if (s < e - 3 || s > e + 3) begin
            n_fail++;
            $display("MISMATCH %s expected %0d seen %0d", nm, e, s);
        end
    endtask
    task send(input [4:0] c);
        @(posedge clk);
        cmdValid <= 1'b1;
        cmdCode <= c;
        @(posedge clk);
        cmdValid <= 1'b0;
        t0 = $time;
    endtask
    task wait_for(input idle);
        integer n;
        n = 0;
        while ((idle ? busy !== 1'b0 : readyN !== 1'b0) && n < 9000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 9000) begin
            n_fail++;
            give_verdict;
        end
    endtask
    task rd(input [3:0] a);
        @(posedge clk);
        rdStrobe <= 1'b1;
        rdAddr <= a;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1 v = rdData_q;
    endtask
    task give_verdict;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (95000) @(posedge clk);
        n_fail++;
        give_verdict;
    end
    initial begin
        cmdTab = '{`TAC_CMD_CONV_X, `TAC_CMD_CONV_Y, `TAC_CMD_SINGLE_X, `TAC_CMD_SINGLE_Y, `TAC_CMD_TEMP_LOW,
            `TAC_CMD_TEMP_HIGH, `TAC_CMD_BAT_QUARTER, `TAC_CMD_BAT_HALF, `TAC_CMD_AUX_A, `TAC_CMD_AUX_B};
        slotTab = '{4'h0, 4'h1, 4'h0, 4'h1, 4'h8, 4'h9, 4'h4, 4'h5, 4'h6, 4'h7};
        seed = $urandom(32'hC80F);
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        penDetect <= 1'b1;
        repeat (40) @(posedge clk);
        #1;
        check_val("pen_touch_irq_n", 16'h0, irqN);
        check_val("busyNoCmd", 16'h0, busy);
        check_val("readyNoCmd", 16'h1, readyN);
        for (i = 0; i < 10; i++) begin
            if (i < 2) begin
                send(`TAC_CMD_DRIVE_X + i);
                @(posedge clk);
                #1 check_val("driverOn", 16'h1, i ? yDrv : xDrv);
                repeat (20) @(posedge clk);
            end
            resSel <= $urandom % 3;
            avgSel <= $urandom % 4;
            level <= $urandom;
            convP <= 8'h01 + $urandom % 4;
            settleC <= $urandom % 20;
            refC <= $urandom % 20;
            send(cmdTab[i]);
            wait_for(0);
            if (i < 4) check_time("touchTime", etime(0, avgSel, resSel), ($time - 1 - t0) / 10);
            else check_time("sensorTime", etime(1, avgSel, resSel), ($time - 1 - t0) / 10);
            wait_for(1);
            check_val("driverOff", 16'h0, {xDrv, yDrv, zDrv});
            rd(slotTab[i]);
            check_val("result", exp_res(level, resSel), v);
            check_val("readyCleared", 16'h1, readyN);
        end
        avgSel <= 2'h0;
        send(`TAC_CMD_DRIVE_Z);
        @(posedge clk);
        #1 check_val("zDriverOn", 16'h1, zDrv);
        repeat (10) @(posedge clk);
        send(($urandom % 2) ? `TAC_CMD_CONV_Z : `TAC_CMD_SINGLE_Z);
        wait_for(0);
        wait_for(1);
        for (i = 2; i < 4; i++) begin
            rd(i);
            check_val("zResult", exp_res(level, resSel), v);
        end
        check_val("zReady", 16'h1, readyN);
        level <= 12'hA5C;
        send(`TAC_CMD_SCAN_XY);
        repeat ((2 * etime(0, 0, resSel) - `TAC_OVH_TOUCH_CYC) * 112 / 100) @(posedge clk);
        #1 check_val("fixedWaitDone", 16'h0, {busy, readyN});
        for (i = 0; i < 2; i++) begin
            rd(i);
            check_val("xyResult", exp_res(12'hA5C, resSel), v);
        end
        send(`TAC_CMD_SCAN_XYZ);
        repeat (30) @(posedge clk);
        send(`TAC_CMD_TEMP_LOW);
        wait_for(1);
        for (i = 0; i < 4; i++) begin
            rd(i);
            check_val("scanResult", exp_res(12'hA5C, resSel), v);
        end
        check_val("scanReady", 16'h1, readyN);
        repeat (5) @(posedge clk);
        #1 check_val("refusedIdle", 16'h0, busy);
        send(`TAC_CMD_TEMP_HIGH);
        repeat (300) @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1 check_val("resetIdle", 16'h0, {busy, xDrv, yDrv, zDrv});
        check_val("resetReady", 16'h1, readyN);
        rd(4'h9);
        check_val("resetResult", 16'h0, v);
        repeat (5) @(posedge clk);
        #1 check_val("irqAfterReset", 16'h0, irqN);
        rd(4'hA);
        check_val("unmapped", 16'h0, v);
        give_verdict;
    end
endmodule
